// >>> design/swl_ctrl.sv
// Control logic of a three-channel LED driver steered by one control line.
// Assumes ctrl_line is synchronous to clk, variant is a static strap and
// supply_ok comes from the analog headroom comparator.
//
// How it works
// [R1] In the edge-counting variants every rising edge of the control line counts once into the step register.
// [R2] After a burst the line stays high and, once the latch time-out runs out, the counted step drives the sinks.
// [R3] A low level lasting the off time-out shuts the driver down, turns the sinks off and zeroes the step register.
// [R4] From shutdown the first rising edge switches the driver on at step 1, the full 20 mA.
// [R5] Each further rising edge before the last step moves one step lower in current.
// [R6] The 16-step variant maps codes 1 to 16 linearly from 20 mA down to 0.63 mA.
// [R7] The 8-step variant maps codes 1 to 8 from 20 mA down to 1.3 mA.
// [R8] The 4-step variant maps codes 1 to 4 to 20, 13.3, 6.7 and 0.87 mA.
// [R9] The host may toggle the line at up to 1 MHz during a burst.
// [R10] Edge-counting variants keep watching the supply in 2x mode and fall back to 1x when it suffices.
// [R11] The PWM variant scales the current with the line's duty cycle, 100% giving 20 mA and 10% about 2.4 mA.
// [R12] The PWM variant shuts down when the line is held low for 1 ms.
// [R13] The PWM variant latches 2x mode and leaves it only through a 1 ms low on the line.
// [R14] The host keeps every low gap in a burst between 0.3 and 75 us.
// [R15] The host keeps every high interval in a burst under 75 us.
// [R16] A rising edge past the last step wraps back to step 1.
`timescale 1ns/1ps

module swl_ctrl #(
	parameter logic [13:0] LATCH_CYC   = 14'(swl_pkg::SWL_LATCH_CYC),
	parameter logic [13:0] OFF_CYC     = 14'(swl_pkg::SWL_OFF_CYC),
	parameter logic [13:0] PWM_OFF_CYC = 14'(swl_pkg::SWL_PWM_OFF_CYC)
)(
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 ctrl_line,
	input  wire swl_pkg::swl_variant_e variant,
	input  wire logic                 supply_ok,
	output swl_pkg::swl_sink_s        led_sink_outputs,
	output logic                      pump_2x
);

	swl_pkg::swl_state_s s_q;
	swl_pkg::swl_state_s s_d;
	logic                rise;
	logic                fall;
	logic [4:0]          step_max;
	logic [11:0]         step_level;

	// Saturating increment keeps a stuck line from wrapping a time-out counter
	function automatic logic [13:0] sat_inc(input logic [13:0] v);
		sat_inc = (v == swl_pkg::SWL_CNT_MAX) ? v : v + swl_pkg::SWL_CNT_ONE;
	endfunction

	// Duty in tenths, rounded to nearest and clamped to 1..10
	function automatic logic [3:0] decile(input logic [13:0] hi, input logic [13:0] per);
		logic [19:0] hi20;
		logic [19:0] per_k;
		decile = swl_pkg::SWL_DUTY_MIN;
		hi20   = {6'h00, hi} * swl_pkg::SWL_DUTY_SCALE;
		for (int k = 2; k <= 10; k++)
		begin
			per_k = {6'h00, per} * 20'(2 * k - 1);
			if (hi20 >= per_k)
				decile = 4'(k);
		end
	endfunction

	assign rise = ctrl_line & ~s_q.pin_q;
	assign fall = ~ctrl_line & s_q.pin_q;

	// Last step code per variant; an illegal strap falls back to 16 steps.
	// Kept apart from the level lookup so no loop runs through the next state
	always_comb
	begin
		step_max = swl_pkg::SWL_MAX16;
		unique case (variant)
			swl_pkg::SWL_VAR16:  step_max = swl_pkg::SWL_MAX16;
			swl_pkg::SWL_VAR8:   step_max = swl_pkg::SWL_MAX8;
			swl_pkg::SWL_VAR4:   step_max = swl_pkg::SWL_MAX4;
			swl_pkg::SWL_VARPWM: step_max = swl_pkg::SWL_MAX16;
			default:             step_max = swl_pkg::SWL_MAX16;
		endcase
	end

	// Next state; line timing is measured in whole clocks, so a 1 MHz burst
	// still gives five samples per level at this clock rate
	always_comb
	begin
		s_d       = s_q;
		s_d.pin_q = ctrl_line;
		// High and low run lengths, restarted at each level change
		if (ctrl_line)
		begin
			s_d.hi_cnt_q = s_q.pin_q ? sat_inc(s_q.hi_cnt_q) : swl_pkg::SWL_CNT_ONE;
			s_d.lo_cnt_q = '0;
		end
		else
		begin
			s_d.lo_cnt_q = s_q.pin_q ? swl_pkg::SWL_CNT_ONE : sat_inc(s_q.lo_cnt_q);
			s_d.hi_cnt_q = '0;
		end
		s_d.per_cnt_q = rise ? swl_pkg::SWL_CNT_ONE : sat_inc(s_q.per_cnt_q);
		if (fall)
			s_d.hi_len_q = s_q.hi_cnt_q;

		if (variant == swl_pkg::SWL_VARPWM)
		begin
			// Duty taken at each later rise from the last whole period; the first rise after shutdown gives full duty
			if (rise)
			begin
				s_d.on_q   = 1'b1;
				s_d.duty_q = s_q.on_q ? decile(s_q.hi_len_q, s_q.per_cnt_q) : swl_pkg::SWL_DUTY_MAX; // [R11]
			end
			if (s_d.hi_cnt_q == PWM_OFF_CYC)
				s_d.duty_q = swl_pkg::SWL_DUTY_MAX; // [R11]
			// 2x is latched so the pump does not hunt on every PWM edge
			if (s_d.on_q && !supply_ok)
				s_d.pump_q = 1'b1; // [R13]
			if (s_d.lo_cnt_q == PWM_OFF_CYC)
			begin
				s_d.on_q   = 1'b0; // [R12]
				s_d.duty_q = '0;
				s_d.pump_q = 1'b0; // [R13]
			end
		end
		else
		begin
			if (rise)
			begin
				if (!s_q.on_q)
				begin
					s_d.on_q      = 1'b1;
					s_d.step_q    = swl_pkg::SWL_STEP_ONE; // [R4]
					s_d.applied_q = swl_pkg::SWL_STEP_ONE; // [R4]
				end
				else if (s_q.step_q >= step_max)
					s_d.step_q = swl_pkg::SWL_STEP_ONE; // [R16]
				else
					s_d.step_q = s_q.step_q + swl_pkg::SWL_STEP_ONE; // [R1] [R5]
			end
			if (s_d.hi_cnt_q == LATCH_CYC)
				s_d.applied_q = s_d.step_q; // [R2]
			if (s_d.lo_cnt_q == OFF_CYC)
			begin
				s_d.on_q      = 1'b0; // [R3]
				s_d.step_q    = '0;
				s_d.applied_q = '0;
			end
			s_d.pump_q = s_d.on_q & ~supply_ok; // [R10]
		end

		// Level lookup on the settled next step or duty, so a latch shows at once
		step_level = '0;
		unique case (variant)
			swl_pkg::SWL_VAR16:  step_level = swl_pkg::SWL_LVL16[4'(s_d.applied_q - swl_pkg::SWL_STEP_ONE)]; // [R6]
			swl_pkg::SWL_VAR8:   step_level = swl_pkg::SWL_LVL8[3'(s_d.applied_q - swl_pkg::SWL_STEP_ONE)]; // [R7]
			swl_pkg::SWL_VAR4:   step_level = swl_pkg::SWL_LVL4[2'(s_d.applied_q - swl_pkg::SWL_STEP_ONE)]; // [R8]
			swl_pkg::SWL_VARPWM: step_level = swl_pkg::SWL_LVLPWM[4'(s_d.duty_q - swl_pkg::SWL_DUTY_MIN)]; // [R11]
			default:             step_level = swl_pkg::SWL_LVL16[4'(s_d.applied_q - swl_pkg::SWL_STEP_ONE)];
		endcase

		// Sinks are off and at zero level whenever the driver is shut down
		s_d.sink_q.en    = {3{s_d.on_q}};
		s_d.sink_q.level = s_d.on_q ? step_level : '0;
	end

	// State register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign led_sink_outputs = s_q.sink_q;
	assign pump_2x          = s_q.pump_q;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	first_edge_on_a: assert property ((variant != swl_pkg::SWL_VARPWM) && rise && !s_q.on_q // [R4]
		|=> s_q.on_q && s_q.step_q == swl_pkg::SWL_STEP_ONE && s_q.sink_q.level == swl_pkg::SWL_LVL16[0])
		else $error("first edge did not switch on at step one");

	step_count_a: assert property ((variant != swl_pkg::SWL_VARPWM) && rise && s_q.on_q // [R5]
		&& s_q.step_q < step_max && !(s_d.lo_cnt_q == OFF_CYC)
		|=> s_q.step_q == $past(s_q.step_q) + swl_pkg::SWL_STEP_ONE)
		else $error("rising edge did not advance the step");

	step_wrap_a: assert property ((variant != swl_pkg::SWL_VARPWM) && rise && s_q.on_q // [R16]
		&& s_q.step_q == step_max |=> s_q.step_q == swl_pkg::SWL_STEP_ONE)
		else $error("step did not wrap after the last code");

	latch_apply_a: assert property ((variant != swl_pkg::SWL_VARPWM) && s_q.on_q // [R2]
		&& ctrl_line && s_q.hi_cnt_q == LATCH_CYC - 14'h0001 |=> s_q.applied_q == s_q.step_q)
		else $error("latch time-out did not apply the step");

	hold_until_latch_a: assert property ((variant != swl_pkg::SWL_VARPWM) && rise && s_q.on_q // [R2]
		|=> $stable(s_q.applied_q))
		else $error("applied step moved before the latch time-out");

	edge_shutdown_a: assert property ((variant != swl_pkg::SWL_VARPWM) && !ctrl_line // [R3]
		&& s_q.lo_cnt_q == OFF_CYC - 14'h0001 |=> !s_q.on_q && s_q.step_q == '0 && s_q.sink_q.en == '0)
		else $error("off time-out did not shut down and clear");

	pump_return_a: assert property ((variant != swl_pkg::SWL_VARPWM) && pump_2x && supply_ok // [R10]
		&& $stable(variant) |=> !pump_2x)
		else $error("edge variant stayed in 2x with supply restored");

	pwm_pump_latch_a: assert property ((variant == swl_pkg::SWL_VARPWM) && pump_2x && supply_ok // [R13]
		&& ctrl_line && $stable(variant) |=> pump_2x [*2])
		else $error("pwm variant left 2x without a long low");

	pwm_shutdown_a: assert property ((variant == swl_pkg::SWL_VARPWM) && !ctrl_line // [R12]
		&& s_q.lo_cnt_q == PWM_OFF_CYC - 14'h0001 |=> !s_q.on_q && !pump_2x && s_q.sink_q.en == '0)
		else $error("pwm variant did not shut down after a long low");

	pwm_full_level_a: assert property ((variant == swl_pkg::SWL_VARPWM) && rise && !s_q.on_q // [R11]
		|=> s_q.sink_q.level == swl_pkg::SWL_LVLPWM[9])
		else $error("pwm turn-on did not start at full current");

endmodule

// >>> design/swl_pkg.sv
// Package for the single-wire LED current control block.
// Assumes a 10 MHz system clock and a control line already synchronous to it.
package swl_pkg;

	// Clock period and the documented time-outs, in their own units
	localparam int SWL_CLK_NS       = 100;
	localparam int SWL_LATCH_US     = 500;
	localparam int SWL_OFF_US       = 500;
	localparam int SWL_PWM_OFF_US   = 1000;
	// Longest times, so cycle counts round down
	localparam int SWL_LATCH_CYC    = (SWL_LATCH_US * 1000) / SWL_CLK_NS;
	localparam int SWL_OFF_CYC      = (SWL_OFF_US * 1000) / SWL_CLK_NS;
	localparam int SWL_PWM_OFF_CYC  = (SWL_PWM_OFF_US * 1000) / SWL_CLK_NS;

	localparam int SWL_CW           = 14;
	localparam logic [13:0] SWL_CNT_MAX  = 14'h3fff;
	localparam logic [13:0] SWL_CNT_ONE  = 14'h0001;
	localparam logic [4:0]  SWL_STEP_ONE = 5'h01;
	localparam logic [4:0]  SWL_MAX16    = 5'h10;
	localparam logic [4:0]  SWL_MAX8     = 5'h08;
	localparam logic [4:0]  SWL_MAX4     = 5'h04;
	localparam logic [3:0]  SWL_DUTY_MIN = 4'h1;
	localparam logic [3:0]  SWL_DUTY_MAX = 4'ha;
	localparam logic [19:0] SWL_DUTY_SCALE = 20'h00014;

	// Sink level, in units of 10 uA, indexed by step code minus one
	localparam logic [11:0] SWL_LVL16 [16] = '{12'h7d0, 12'h74e, 12'h6c2, 12'h640, 12'h5be, 12'h532,
		12'h4b0, 12'h42e, 12'h3a2, 12'h320, 12'h29e, 12'h212, 12'h190, 12'h10e, 12'h082, 12'h03f};
	localparam logic [11:0] SWL_LVL8 [8] = '{12'h7d0, 12'h6c2, 12'h5be, 12'h4b0, 12'h3a2, 12'h29e,
		12'h190, 12'h082};
	localparam logic [11:0] SWL_LVL4 [4] = '{12'h7d0, 12'h532, 12'h29e, 12'h057};
	// PWM level indexed by duty in tenths minus one (10% .. 100%)
	localparam logic [11:0] SWL_LVLPWM [10] = '{12'h0f0, 12'h1ae, 12'h276, 12'h334, 12'h3f2, 12'h4ba,
		12'h578, 12'h636, 12'h6fe, 12'h7d0};

	// Product variant strap, one-hot
	typedef enum logic [3:0] {
		SWL_VAR16  = 4'h1,
		SWL_VAR8   = 4'h2,
		SWL_VAR4   = 4'h4,
		SWL_VARPWM = 4'h8
	} swl_variant_e;

	// Drive towards the three current sinks
	typedef struct packed {
		logic [2:0]  en;
		logic [11:0] level;
	} swl_sink_s;

	// Whole state of the controller
	typedef struct packed {
		logic        pin_q;
		logic        on_q;
		logic [4:0]  step_q;
		logic [4:0]  applied_q;
		logic [13:0] hi_cnt_q;
		logic [13:0] lo_cnt_q;
		logic [13:0] per_cnt_q;
		logic [13:0] hi_len_q;
		logic [3:0]  duty_q;
		logic        pump_q;
		swl_sink_s   sink_q;
	} swl_state_s;

endpackage

// >>> testbench/swl_host.sv
// Host model that drives the single control line.
// Assumes the bench calls its tasks just after a rising clk edge.
`timescale 1ns/1ps

module swl_host (
	input  wire logic clk,
	output logic      ctrl_line
);
	initial ctrl_line = 1'b0;

	// Hold one level for n cycles, changed just after the edge
	task automatic lvl(input logic v, input int n);
		ctrl_line <= v;
		repeat (n) @(posedge clk);
	endtask

	// Rising-edge burst; 5 to 7 cycle levels stay under 1 MHz and far below 75 us
	task automatic burst(input int n, input int h, input int l);
		repeat (n)
		begin
			lvl(1'b0, l);
			lvl(1'b1, h);
		end
	endtask

	// Steady duty cycle, k periods, each starting with a rise
	task automatic pwm(input int h, input int l, input int k);
		repeat (k)
		begin
			lvl(1'b1, h);
			lvl(1'b0, l);
		end
	endtask
endmodule

// >>> testbench/tb_single_wire_led_current_control.sv
// Self-checking bench for the LED current controller.
// Assumes short time-outs of 20/20/40 cycles, longer than any burst gap.
`timescale 1ns/1ps

module tb_single_wire_led_current_control;
	localparam logic [13:0] LAT  = 14'h0014;
	localparam logic [13:0] POFF = 14'h0028;
	logic                  clk       = 1'b0;
	logic                  rst_n     = 1'b0;
	logic                  supply_ok = 1'b1;
	logic                  ctrl_line;
	logic                  pump_2x;
	swl_pkg::swl_variant_e variant   = swl_pkg::SWL_VAR16;
	swl_pkg::swl_sink_s    led_sink_outputs;
	swl_pkg::swl_sink_s    prev_q;
	swl_pkg::swl_sink_s    exp_q[$];
	int                    failures  = 0;
	int                    n_checks  = 0;
	int                    seed      = 35177;

	always #50 clk = ~clk;

	swl_host host (.clk(clk), .ctrl_line(ctrl_line));

	swl_ctrl #(.LATCH_CYC(LAT), .OFF_CYC(LAT), .PWM_OFF_CYC(POFF)) dut (
		.clk(clk), .rst_n(rst_n), .ctrl_line(ctrl_line), .variant(variant),
		.supply_ok(supply_ok), .led_sink_outputs(led_sink_outputs), .pump_2x(pump_2x));

	task automatic chk(input string what, input logic [14:0] e, input logic [14:0] g);
		n_checks++;
		if (g !== e)
		begin
			failures++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic note(input logic [2:0] en, input logic [11:0] l);
		exp_q.push_back(swl_pkg::swl_sink_s'{en: en, level: l});
	endtask

	function automatic logic [11:0] lvl_of(input int i);
		case (variant)
			swl_pkg::SWL_VAR8: return swl_pkg::SWL_LVL8[i];
			swl_pkg::SWL_VAR4: return swl_pkg::SWL_LVL4[i];
			default: return swl_pkg::SWL_LVL16[i];
		endcase
	endfunction

	function automatic int rnd();
		return 5 + ($unsigned($random(seed)) % 3);
	endfunction

	task automatic do_reset;
		rst_n <= 1'b0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
	endtask

	// Any change of the sink drive must match the oldest note
	always @(posedge clk)
	begin
		if (rst_n && led_sink_outputs !== prev_q)
		begin
			if (exp_q.size() == 0)
				chk("sink spurious", prev_q, led_sink_outputs);
			else
				chk("sink", exp_q.pop_front(), led_sink_outputs);
		end
		prev_q <= led_sink_outputs;
	end

	// Step n from shutdown, latch it with the supply short, then shut down
	task automatic edge_run(input int n, input int ns);
		int s;
		s = (n - 1) % ns;
		note(3'h7, lvl_of(0));
		if (s != 0)
			note(3'h7, lvl_of(s));
		host.burst(n, rnd(), rnd());
		supply_ok <= 1'b0;
		host.lvl(1'b1, LAT + 3);
		chk("pump on", 15'(1), 15'(pump_2x));
		supply_ok <= 1'b1;
		host.lvl(1'b1, 3);
		chk("pump back", 15'(0), 15'(pump_2x));
		note(3'h0, 12'h000);
		host.lvl(1'b0, LAT + 3);
	endtask

	// Every code of every edge variant, plus one rise past the end
	initial
	begin
		swl_pkg::swl_variant_e vs[3];
		int ns[3];
		vs = '{swl_pkg::SWL_VAR16, swl_pkg::SWL_VAR8, swl_pkg::SWL_VAR4};
		ns = '{16, 8, 4};
		foreach (vs[i])
		begin
			variant <= vs[i];
			do_reset();
			for (int n = 1; n <= ns[i] + 1; n++)
				edge_run(n, ns[i]);
			$display("edge variant %0d done", ns[i]);
		end
		variant <= swl_pkg::SWL_VARPWM;
		do_reset();
		note(3'h7, swl_pkg::SWL_LVLPWM[9]);
		note(3'h7, swl_pkg::SWL_LVLPWM[4]);
		note(3'h7, swl_pkg::SWL_LVLPWM[0]);
		supply_ok <= 1'b0;
		host.pwm(10, 10, 4);
		supply_ok <= 1'b1;
		host.pwm(2, 18, 3);
		chk("pump latched", 15'(1), 15'(pump_2x));
		// A line held high past the off time-out means full duty
		note(3'h7, swl_pkg::SWL_LVLPWM[9]);
		host.lvl(1'b1, POFF + 3);
		note(3'h0, 12'h000);
		host.lvl(1'b0, POFF + 3);
		chk("pump cleared", 15'(0), 15'(pump_2x));
		chk("notes left", 15'(0), 15'(exp_q.size()));
		$display("pwm variant done");
		finish_test();
	end

	// A hang counts as a mismatch; the run needs about 4400 cycles
	initial
	begin
		repeat (30000) @(posedge clk);
		failures++;
		$display("BAD watchdog expected end seen hang");
		finish_test();
	end
endmodule
